// ==== design/srbp_top.sv ====
// Host-facing serial port of a serial-to-radio bridge with buffer and mode control.
// Assumes host pins synchronous to sys_clk; radio side is a valid/ready byte port.
//
// Notes on behaviour
// - Bit rate selectable from 1200 to 230400 bit/s; host uses the same.
// - Characters are always eight data bits.
// - Parity none, even or odd, generated on send and checked on receive.
// - Host bytes buffered and sent per packet, packet retried until done.
// - Flow control on: drop RTS when buffer is one byte short of full.
// - Flow control on: raise RTS again once buffer has drained enough.
// - Flow control off: full buffer is discarded to make room.
// - Command mode: silent at reset, no role, waits for commands.
// - Configuration and commands accepted only in command mode; a mode write back to command mode with no setting write in the same cycle is accepted in any mode.
// - Operation mode kept over soft reset; hard reset returns to command mode.
// - Last connected peer address kept; none after hard reset.
// - Peer address is twelve hex digits, 48 bits.
// - Auto-connect master mode: master, tries stored peer at every soft reset.
// - Auto-connect master mode: not discoverable, not connectable.
// - Auto and paired modes need a stored peer address.
// - Paired-wait slave mode: slave, only stored peer may connect.
// - Paired-wait slave mode: undiscoverable, other peers refused.
// - Open-wait slave mode: discoverable, any peer accepted.
// - Four responses sent to host unless responses are switched off.
`timescale 1ns/1ps
module srbp_top
  import srbp_pkg::*;
#(
  parameter int unsigned DEPTH     = 64,   // Buffer bytes
  parameter int unsigned RESUME    = 48,   // RTS resume level
  parameter int unsigned PKT_BYTES = 16    // Bytes per radio packet
) (
  input  wire logic                 sys_clk,        // System clock
  input  wire logic                 rst,            // Sync reset, hard reset
  input  wire logic                 soft_rst,       // Soft reset pulse
  input  wire logic                 rxd,            // Host serial data in
  output logic                      txd,            // Serial data to host
  output logic                      rts,            // Ready to accept host data
  input  wire srbp_cfg_s            cfg_in,         // Serial setting to load
  input  wire logic                 cfg_wr,         // Load serial setting
  input  wire logic [1:0]           mode_in,        // Mode code to load
  input  wire logic                 mode_wr,        // Load mode
  output srbp_cfg_s                 cfg,            // Active serial setting
  output srbp_mode_e                mode,           // Active mode
  output logic                      cmd_refused,    // Write refused pulse
  output logic                      cmd_active,     // Host bytes are commands
  output logic [DATA_BITS-1:0]      cmd_data,       // Command byte
  output logic                      cmd_valid,      // Command byte pulse
  output logic                      par_err,        // Parity error pulse
  output logic                      drop,           // Buffer discarded pulse
  output logic [DATA_BITS-1:0]      radio_data,     // Byte to radio
  output logic                      radio_valid,    // Byte offered
  input  wire logic                 radio_ready,    // Radio took byte
  output logic                      radio_pkt_end,  // Last byte of packet
  input  wire logic                 pkt_done,       // Packet delivered
  input  wire logic                 pkt_fail,       // Packet failed, retry
  input  wire logic                 link_up,        // Connection made pulse
  input  wire logic                 link_down,      // Connection lost pulse
  input  wire logic [ADDR_BITS-1:0] link_peer,      // Address of new peer
  output logic [ADDR_BITS-1:0]      peer_addr,      // Stored peer address
  output logic                      peer_valid,     // Peer stored
  output srbp_radio_s               radio,          // Radio role and filter
  input  wire logic                 resp_req,       // Send response pulse
  input  wire logic [2:0]           resp_code       // Response select
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [DATA_BITS-1:0] mem [DEPTH];
  logic [AW-1:0]        wr_ptr_reg;
  logic [AW-1:0]        rd_ptr_reg;
  logic [AW-1:0]        pkt_ptr_reg;
  logic [AW:0]          cnt_reg;
  logic [AW:0]          sent_reg;
  logic [AW:0]          pkt_len_reg;
  logic                 pkt_busy_reg;
  logic                 wait_reg;
  logic [DIV_BITS-1:0]  divisor;
  logic [DATA_BITS-1:0] rx_data;
  logic                 rx_valid;
  logic                 rx_perr;
  logic                 tx_ready;
  logic                 tx_start;
  logic [DATA_BITS-1:0] tx_byte;
  logic                 push;
  logic                 pop;
  logic                 full;
  logic                 retry;
  logic                 release_pkt;
  logic                 discard;
  logic [3:0]           resp_idx_reg;
  logic [3:0]           resp_len_reg;
  logic [2:0]           resp_code_reg;
  logic                 resp_busy_reg;
  logic                 boot_reg;

  assign divisor = srbp_divisor(cfg.rate_sel);
  assign full    = (cnt_reg == (AW+1)'(DEPTH));

  srbp_uart_rx u_rx (
    .sys_clk (sys_clk),
    .rst     (rst),
    .divisor (divisor),
    .parity  (cfg.parity),
    .rxd     (rxd),
    .data    (rx_data),
    .valid   (rx_valid),
    .par_err (rx_perr)
  );

  srbp_uart_tx u_tx (
    .sys_clk (sys_clk),
    .rst     (rst),
    .divisor (divisor),
    .parity  (cfg.parity),
    .start   (tx_start),
    .data    (tx_byte),
    .ready   (tx_ready),
    .txd     (txd)
  );

  // Serial setting writable only in command mode; outside it mode can only go back to command
  always_ff @(posedge sys_clk) begin
    cmd_refused <= 1'b0;
    if (rst) begin
      cfg  <= CFG_RESET;
      mode <= SRBP_CMD;
    end else if (mode == SRBP_CMD) begin
      if (cfg_wr) begin
        cfg <= cfg_in;
      end
      if (mode_wr) begin
        unique case (mode_in)
          MODE_CODE_CMD:  mode <= SRBP_CMD;
          MODE_CODE_AUTO: if (peer_valid) mode <= SRBP_AUTO; else cmd_refused <= 1'b1;
          MODE_CODE_PAIR: if (peer_valid) mode <= SRBP_PAIR; else cmd_refused <= 1'b1;
          MODE_CODE_OPEN: mode <= SRBP_OPEN;
        endcase
      end
    end else if (cfg_wr || (mode_wr && mode_in != MODE_CODE_CMD)) begin
      cmd_refused <= 1'b1;
    end else if (mode_wr) begin
      mode <= SRBP_CMD;
    end
  end

  // Last peer address, cleared only by hard reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      peer_addr  <= PEER_RESET;
      peer_valid <= 1'b0;
    end else if (link_up) begin
      peer_addr  <= link_peer;
      peer_valid <= 1'b1;
    end
  end

  // Radio role per mode; a connect attempt follows each soft reset in auto mode with a stored peer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      radio    <= '0;
      boot_reg <= 1'b1;
    end else begin
      boot_reg           <= soft_rst;
      radio.try_connect  <= 1'b0;
      radio.role_master  <= (mode == SRBP_AUTO);
      radio.role_slave   <= (mode == SRBP_PAIR) || (mode == SRBP_OPEN);
      radio.discoverable <= (mode == SRBP_OPEN);
      radio.connectable  <= (mode == SRBP_PAIR) || (mode == SRBP_OPEN);
      radio.filter_peer  <= (mode == SRBP_PAIR);
      if (boot_reg && mode == SRBP_AUTO && peer_valid) begin
        radio.try_connect <= 1'b1;
      end
    end
  end

  // Host bytes: commands in command mode, else into the buffer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_active <= 1'b1;
      cmd_valid  <= 1'b0;
      cmd_data   <= '0;
      par_err    <= 1'b0;
    end else begin
      cmd_active <= (mode == SRBP_CMD);
      cmd_valid  <= rx_valid && !rx_perr && (mode == SRBP_CMD);
      par_err    <= rx_valid && rx_perr;
      if (rx_valid) begin
        cmd_data <= rx_data;
      end
    end
  end

  assign push        = rx_valid && !rx_perr && (mode != SRBP_CMD) && !full;
  assign pop         = radio_valid && radio_ready;
  assign retry       = pkt_busy_reg && wait_reg && pkt_fail;
  assign release_pkt = pkt_busy_reg && wait_reg && pkt_done;
  // Packet in flight is lost too, else a full buffer never empties
  assign discard     = full && !cfg.flow_en;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= rx_data;
    end
  end

  // Buffer pointers; bytes stay stored until their packet is delivered
  always_ff @(posedge sys_clk) begin
    drop <= 1'b0;
    if (rst || soft_rst) begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      pkt_ptr_reg  <= '0;
      cnt_reg      <= '0;
      sent_reg     <= '0;
      pkt_len_reg  <= '0;
      pkt_busy_reg <= 1'b0;
      wait_reg     <= 1'b0;
    end else if (discard) begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      pkt_ptr_reg  <= '0;
      cnt_reg      <= '0;
      sent_reg     <= '0;
      pkt_len_reg  <= '0;
      pkt_busy_reg <= 1'b0;
      wait_reg     <= 1'b0;
      drop         <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= AW'((wr_ptr_reg + 1'b1) % DEPTH);
      end
      if (!pkt_busy_reg && cnt_reg != '0) begin
        pkt_busy_reg <= 1'b1;
        sent_reg     <= '0;
        pkt_len_reg  <= (cnt_reg > (AW+1)'(PKT_BYTES)) ? (AW+1)'(PKT_BYTES) : cnt_reg;
        rd_ptr_reg   <= pkt_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= AW'((rd_ptr_reg + 1'b1) % DEPTH);
        sent_reg   <= sent_reg + 1'b1;
        if (sent_reg + 1'b1 == pkt_len_reg) begin
          wait_reg <= 1'b1;
        end
      end
      if (retry) begin
        rd_ptr_reg <= pkt_ptr_reg;
        sent_reg   <= '0;
        wait_reg   <= 1'b0;
      end
      if (release_pkt) begin
        pkt_ptr_reg  <= AW'((pkt_ptr_reg + pkt_len_reg) % DEPTH);
        pkt_busy_reg <= 1'b0;
        wait_reg     <= 1'b0;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (release_pkt ? pkt_len_reg : '0);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || soft_rst) begin
      radio_valid   <= 1'b0;
      radio_data    <= '0;
      radio_pkt_end <= 1'b0;
    end else begin
      radio_valid   <= pkt_busy_reg && !wait_reg && !retry && !pop && !discard && (sent_reg < pkt_len_reg);
      radio_data    <= mem[rd_ptr_reg];
      radio_pkt_end <= (sent_reg + 1'b1 == pkt_len_reg);
    end
  end

  // RTS with hysteresis between one byte short of full and the resume level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rts <= 1'b1;
    end else if (!cfg.flow_en) begin
      rts <= 1'b1;
    end else if (cnt_reg >= (AW+1)'(DEPTH) - 1'b1) begin
      rts <= 1'b0;
    end else if (cnt_reg <= (AW+1)'(RESUME)) begin
      rts <= 1'b1;
    end
  end

  // Response text to host, suppressed when responses are off
  function automatic logic [DATA_BITS-1:0] resp_char(input logic [2:0] code, input logic [3:0] idx);
    logic [8*12-1:0] s;
    s = '0;
    unique case (code)
      RESP_OK:      s = {"\r\nOK\r\n", 48'h0};
      RESP_ERROR:   s = {"\r\nERROR\r\n", 24'h0};
      RESP_CONNECT: s = {"\r\nCONNECT\r\n", 8'h0};
      default:      s = {"\r\nDISCONNECT"};
    endcase
    return s[8*(11 - idx) +: 8];
  endfunction

  assign tx_byte  = resp_char(resp_code_reg, resp_idx_reg);
  assign tx_start = resp_busy_reg && tx_ready;

  always_ff @(posedge sys_clk) begin
    if (rst || soft_rst) begin
      resp_busy_reg <= 1'b0;
      resp_idx_reg  <= '0;
      resp_len_reg  <= '0;
      resp_code_reg <= RESP_OK;
    end else if (!resp_busy_reg) begin
      if (cfg.resp_en && (resp_req || link_up || link_down)) begin
        resp_busy_reg <= 1'b1;
        resp_idx_reg  <= '0;
        resp_code_reg <= link_up ? RESP_CONNECT : (link_down ? RESP_DISCON : resp_code);
        unique case (link_up ? RESP_CONNECT : (link_down ? RESP_DISCON : resp_code))
          RESP_OK:      resp_len_reg <= 4'h6;
          RESP_ERROR:   resp_len_reg <= 4'h9;
          RESP_CONNECT: resp_len_reg <= 4'hb;
          default:      resp_len_reg <= 4'hc;
        endcase
      end
    end else if (tx_start) begin
      resp_idx_reg <= resp_idx_reg + 4'h1;
      if (resp_idx_reg + 4'h1 == resp_len_reg) begin
        resp_busy_reg <= 1'b0;
      end
    end
  end
endmodule

// ==== design/srbp_pkg.sv ====
// Shared constants and types for the serial radio bridge port.
// Assumes a single 125 MHz system clock.
package srbp_pkg;
  localparam int unsigned SYS_CLK_HZ     = 125000000;
  localparam int unsigned DATA_BITS      = 8;
  localparam int unsigned ADDR_BITS      = 48;
  localparam int unsigned ADDR_DIGITS    = 12;
  localparam int unsigned RATE_COUNT     = 9;
  localparam logic [3:0]  RATE_RESET     = 4'h3;
  localparam int unsigned DIV_BITS       = 17;
  localparam logic [47:0] PEER_RESET     = 48'h0;
  localparam logic [1:0]  PARITY_NONE    = 2'h0;
  localparam logic [1:0]  PARITY_EVEN    = 2'h1;
  localparam logic [1:0]  PARITY_ODD     = 2'h2;
  localparam logic [2:0]  RESP_OK        = 3'h0;
  localparam logic [2:0]  RESP_ERROR     = 3'h1;
  localparam logic [2:0]  RESP_CONNECT   = 3'h2;
  localparam logic [2:0]  RESP_DISCON    = 3'h3;

  // Rates in bit/s, index order matches the rate select code
  function automatic logic [DIV_BITS-1:0] srbp_divisor(input logic [3:0] sel);
    int unsigned bps;
    bps = 9600;
    unique case (sel)
      4'h0: bps = 1200;
      4'h1: bps = 2400;
      4'h2: bps = 4800;
      4'h3: bps = 9600;
      4'h4: bps = 19200;
      4'h5: bps = 38400;
      4'h6: bps = 57600;
      4'h7: bps = 115200;
      4'h8: bps = 230400;
      default: bps = 9600;
    endcase
    return DIV_BITS'(SYS_CLK_HZ / bps - 1);
  endfunction

  typedef enum logic [3:0] {
    SRBP_CMD  = 4'b0001,
    SRBP_AUTO = 4'b0010,
    SRBP_PAIR = 4'b0100,
    SRBP_OPEN = 4'b1000
  } srbp_mode_e;

  localparam logic [1:0] MODE_CODE_CMD  = 2'h0;
  localparam logic [1:0] MODE_CODE_AUTO = 2'h1;
  localparam logic [1:0] MODE_CODE_PAIR = 2'h2;
  localparam logic [1:0] MODE_CODE_OPEN = 2'h3;

  typedef struct packed {
    logic [3:0] rate_sel;
    logic [1:0] parity;
    logic       flow_en;
    logic       resp_en;
  } srbp_cfg_s;

  localparam srbp_cfg_s CFG_RESET = '{rate_sel: 4'h3, parity: 2'h0, flow_en: 1'b0, resp_en: 1'b1};

  typedef struct packed {
    logic       role_master;
    logic       role_slave;
    logic       discoverable;
    logic       connectable;
    logic       filter_peer;
    logic       try_connect;
  } srbp_radio_s;
endpackage

// ==== design/srbp_uart_rx.sv ====
// Serial receiver: 8 data bits, optional parity, one stop bit.
// Assumes rxd is synchronous to sys_clk.
`timescale 1ns/1ps
module srbp_uart_rx
  import srbp_pkg::*;
(
  input  wire logic                sys_clk,   // System clock
  input  wire logic                rst,       // Sync reset
  input  wire logic [DIV_BITS-1:0] divisor,   // Cycles per bit minus one
  input  wire logic [1:0]          parity,    // Parity select
  input  wire logic                rxd,       // Serial input
  output logic [DATA_BITS-1:0]     data,      // Received byte
  output logic                     valid,     // Byte pulse
  output logic                     par_err    // Parity error with valid
);
  logic [DIV_BITS-1:0] cnt_reg;
  logic [3:0]          bit_reg;
  logic                busy_reg;
  logic [8:0]          shf_reg;
  logic                has_par;

  assign has_par = (parity != PARITY_NONE);

  always_ff @(posedge sys_clk) begin
    valid <= 1'b0;
    if (rst) begin
      busy_reg <= 1'b0;
      cnt_reg  <= '0;
      bit_reg  <= '0;
      shf_reg  <= '0;
      data     <= '0;
      par_err  <= 1'b0;
    end else if (!busy_reg) begin
      if (!rxd) begin
        busy_reg <= 1'b1;
        cnt_reg  <= divisor >> 1;
        bit_reg  <= '0;
      end
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end else begin
      cnt_reg <= divisor;
      bit_reg <= bit_reg + 4'h1;
      if (bit_reg == 4'h0 && rxd) begin
        busy_reg <= 1'b0;
      end else if (bit_reg >= 4'h1 && bit_reg <= 4'h9) begin
        shf_reg <= {rxd, shf_reg[8:1]};
      end
      if ((has_par && bit_reg == 4'ha) || (!has_par && bit_reg == 4'h9)) begin
        busy_reg <= 1'b0;
        valid    <= rxd;
        data     <= has_par ? shf_reg[7:0] : shf_reg[8:1];
        par_err  <= has_par && ((^shf_reg) != (parity == PARITY_ODD));
      end
    end
  end
endmodule

// ==== design/srbp_uart_tx.sv ====
// Serial transmitter: 8 data bits, optional parity, one stop bit.
// Assumes start is only raised while ready is high.
`timescale 1ns/1ps
module srbp_uart_tx
  import srbp_pkg::*;
(
  input  wire logic                sys_clk,   // System clock
  input  wire logic                rst,       // Sync reset
  input  wire logic [DIV_BITS-1:0] divisor,   // Cycles per bit minus one
  input  wire logic [1:0]          parity,    // Parity select
  input  wire logic                start,     // Send request
  input  wire logic [DATA_BITS-1:0] data,     // Byte to send
  output logic                     ready,     // Idle
  output logic                     txd        // Serial output
);
  logic [DIV_BITS-1:0] cnt_reg;
  logic [3:0]          left_reg;
  logic [10:0]         shf_reg;
  logic                par_bit;

  assign par_bit = (^data) ^ (parity == PARITY_ODD);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_reg  <= '0;
      left_reg <= '0;
      shf_reg  <= '1;
      ready    <= 1'b1;
      txd      <= 1'b1;
    end else if (left_reg == 4'h0) begin
      ready <= 1'b1;
      txd   <= 1'b1;
      if (start) begin
        ready    <= 1'b0;
        cnt_reg  <= divisor;
        txd      <= 1'b0;
        if (parity != PARITY_NONE) begin
          shf_reg  <= {1'b1, 1'b1, par_bit, data};
          left_reg <= 4'hb; // Last step ends a full stop bit
        end else begin
          shf_reg  <= {1'b1, 1'b1, 1'b1, data};
          left_reg <= 4'ha;
        end
      end
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end else begin
      cnt_reg  <= divisor;
      txd      <= shf_reg[0];
      shf_reg  <= {1'b1, shf_reg[10:1]};
      left_reg <= left_reg - 4'h1;
    end
  end
endmodule

// ==== tb/srbp_top_checker.sv ====
// Concurrent checks on the bridge port top-level ports.
// Assumes one clock domain with the synchronous reset rst.
`timescale 1ns/1ps
module srbp_top_checker
  import srbp_pkg::*;
(
  input wire logic                 sys_clk,      // Clock
  input wire logic                 rst,          // Reset
  input wire logic                 soft_rst,     // Soft reset
  input wire logic                 cfg_wr,       // Setting write
  input wire logic                 mode_wr,      // Mode write
  input wire logic [1:0]           mode_in,      // Mode code
  input wire srbp_cfg_s            cfg,          // Setting
  input wire srbp_mode_e           mode,         // Mode
  input wire logic                 cmd_refused,  // Refusal
  input wire logic                 drop,         // Discard
  input wire logic [DATA_BITS-1:0] radio_data,   // Offered byte
  input wire logic                 radio_valid,  // Offer
  input wire logic                 radio_ready,  // Taken
  input wire logic                 link_up,      // Connected
  input wire logic [ADDR_BITS-1:0] link_peer,    // New peer
  input wire logic [ADDR_BITS-1:0] peer_addr,    // Stored peer
  input wire logic                 peer_valid,   // Peer stored
  input wire srbp_radio_s          radio         // Role
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_cfg_refused: assert property (cfg_wr && mode != SRBP_CMD |=> $stable(cfg))
    else $error("setting changed outside command mode");
  a_mode_cmd: assert property (mode_wr && mode_in == MODE_CODE_CMD |=> mode == SRBP_CMD)
    else $error("command mode not entered");
  a_no_peer: assert property (mode_wr && mode_in == MODE_CODE_AUTO && !peer_valid && mode == SRBP_CMD
    && !link_up |=> mode == SRBP_CMD ##[0:1] cmd_refused)
    else $error("auto mode taken without peer");
  a_peer_kept: assert property (link_up |=> peer_valid && peer_addr == $past(link_peer))
    else $error("peer address not stored");
  a_cmd_role: assert property (mode == SRBP_CMD ##1 mode == SRBP_CMD |-> !radio.role_master && !radio.role_slave)
    else $error("role taken in command mode");
  a_auto_role: assert property (mode == SRBP_AUTO ##1 mode == SRBP_AUTO
    |-> radio.role_master && !radio.discoverable && !radio.connectable)
    else $error("auto mode radio state wrong");
  a_pair_role: assert property (mode == SRBP_PAIR ##1 mode == SRBP_PAIR
    |-> radio.role_slave && radio.filter_peer && !radio.discoverable)
    else $error("paired mode radio state wrong");
  a_open_role: assert property (mode == SRBP_OPEN ##1 mode == SRBP_OPEN
    |-> radio.discoverable && radio.connectable && !radio.filter_peer)
    else $error("open mode radio state wrong");
  a_offer_hold: assert property (radio_valid && !radio_ready && !soft_rst
    |=> drop || (radio_valid && $stable(radio_data)))
    else $error("offered byte withdrawn");
  a_drop_flow: assert property (cfg.flow_en && $past(cfg.flow_en) |-> !drop)
    else $error("discard with flow control on");
endmodule

bind srbp_top srbp_top_checker u_chk (.sys_clk(sys_clk), .rst(rst), .soft_rst(soft_rst), .cfg_wr(cfg_wr),
  .mode_wr(mode_wr), .mode_in(mode_in), .cfg(cfg), .mode(mode), .cmd_refused(cmd_refused), .drop(drop),
  .radio_data(radio_data), .radio_valid(radio_valid), .radio_ready(radio_ready), .link_up(link_up),
  .link_peer(link_peer), .peer_addr(peer_addr), .peer_valid(peer_valid), .radio(radio));

// ==== tb/srbp_host_model.sv ====
// Host serial device: sends framed bytes on rxd, counts txd edges.
// Assumes 8 data bits, one stop bit, bit time counted in sys_clk.
`timescale 1ns/1ps
module srbp_host_model
  import srbp_pkg::*;
#(
  parameter int BIT_CYC = 542  // Clocks per bit
) (
  input  wire logic sys_clk,   // Clock
  input  wire logic rts,       // Device ready
  input  wire logic txd,       // Device serial out
  output logic      rxd,       // Host serial out
  output int        tx_falls   // Falling edges on txd
);
  logic txd_q = 1'b1;
  initial rxd = 1'b1;
  initial tx_falls = 0;
  always @(posedge sys_clk) begin
    txd_q <= txd;
    if (txd_q === 1'b1 && txd === 1'b0) tx_falls <= tx_falls + 1;
  end

  task automatic send(input logic [7:0] b, input logic [1:0] par, input logic bad, output logic ok);
    logic [10:0] fr;
    int          n;
    int          i;
    fr = {1'b1, (par == PARITY_ODD) ^ (^b) ^ bad, b, 1'b0};
    if (par == PARITY_NONE) fr[9] = 1'b1;
    n = (par == PARITY_NONE) ? 10 : 11;
    for (i = 0; i < 20000 && rts !== 1'b1; i++) @(posedge sys_clk);
    ok = (rts === 1'b1);
    for (i = 0; i < n; i++) begin
      @(posedge sys_clk);
      rxd <= fr[i];
      repeat (BIT_CYC - 1) @(posedge sys_clk);
    end
  endtask
endmodule

// ==== tb/srbp_top_test.sv ====
// Bench for the bridge port: modes, framing, buffer and flow control.
// Assumes the host model on the serial pins and a 125 MHz clock.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error %0t: got %h, expected %h", $time, (a), (b)); end end
module srbp_top_test
  import srbp_pkg::*;
;
  logic        sys_clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, mode_wr = 1'b0, radio_ready = 1'b0, ok;
  logic [4:0]  pls = 5'h00;
  logic [1:0]  mode_in = 2'h0;
  logic [47:0] link_peer = 48'h0123456789ab, peer_addr;
  srbp_cfg_s   cfg_in = CFG_RESET, cfg;
  srbp_mode_e  mode;
  srbp_radio_s radio;
  logic        rxd, txd, rts, cmd_refused, cmd_active, cmd_valid, par_err, drop, radio_valid, radio_pkt_end;
  logic        peer_valid;
  logic [7:0]  cmd_data, radio_data, last_cmd;
  int          n_mismatch = 0, cmp_count = 0, n_cmd = 0, n_par = 0, n_drop = 0, n_ref = 0, falls, i, k;

  always #4 sys_clk = ~sys_clk;

  srbp_top #(.DEPTH(4), .RESUME(2), .PKT_BYTES(2)) uut (.sys_clk(sys_clk), .rst(rst), .soft_rst(pls[0]),
    .rxd(rxd), .txd(txd), .rts(rts), .cfg_in(cfg_in), .cfg_wr(cfg_wr), .mode_in(mode_in), .mode_wr(mode_wr),
    .cfg(cfg), .mode(mode), .cmd_refused(cmd_refused), .cmd_active(cmd_active), .cmd_data(cmd_data),
    .cmd_valid(cmd_valid), .par_err(par_err), .drop(drop), .radio_data(radio_data), .radio_valid(radio_valid),
    .radio_ready(radio_ready), .radio_pkt_end(radio_pkt_end), .pkt_done(pls[1]), .pkt_fail(pls[2]),
    .link_up(pls[3]), .link_down(1'b0), .link_peer(link_peer), .peer_addr(peer_addr), .peer_valid(peer_valid),
    .radio(radio), .resp_req(pls[4]), .resp_code(RESP_OK));
  srbp_host_model #(.BIT_CYC(125000000 / 230400)) host (.sys_clk(sys_clk), .rts(rts), .txd(txd), .rxd(rxd),
    .tx_falls(falls));

  always @(posedge sys_clk) begin
    if (cmd_valid === 1'b1) last_cmd <= cmd_data;
    n_cmd  <= n_cmd + int'(cmd_valid === 1'b1);
    n_par  <= n_par + int'(par_err === 1'b1);
    n_drop <= n_drop + int'(drop === 1'b1);
    n_ref  <= n_ref + int'(cmd_refused === 1'b1);
  end

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic pulse(input int p);
    @(posedge sys_clk);
    pls[p] <= 1'b1;
    @(posedge sys_clk);
    pls <= 5'h00;
  endtask
  task automatic await(ref int c, input int t);
    int j;
    for (j = 0; j < 8000 && c < t; j++) @(posedge sys_clk);
    if (c < t) begin
      $display("Error %0t: wait ran out", $time);
      n_mismatch++;
      complete_run();
    end
  endtask
  task automatic wr_cfg(input logic [3:0] r, input logic [1:0] p, input logic f, input logic e);
    @(posedge sys_clk);
    cfg_in <= '{r, p, f, e};
    cfg_wr <= 1'b1;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    cyc(3);
  endtask
  task automatic wr_mode(input logic [1:0] c);
    @(posedge sys_clk);
    mode_in <= c;
    mode_wr <= 1'b1;
    @(posedge sys_clk);
    mode_wr <= 1'b0;
    cyc(3);
  endtask
  task automatic tx(input logic [7:0] b, input logic [1:0] p, input logic bad);
    host.send(b, p, bad, ok);
    `CHK(ok, 1'b1)
    cyc(20);
  endtask
  task automatic pop(input logic [7:0] d, input logic e);
    int j;
    @(posedge sys_clk);
    for (j = 0; j < 100 && radio_valid !== 1'b1; j++) @(posedge sys_clk);
    radio_ready <= 1'b1;
    @(posedge sys_clk);
    `CHK({radio_valid, radio_data, radio_pkt_end}, {1'b1, d, e})
    radio_ready <= 1'b0;
  endtask

  initial begin
    cyc(20);
    rst <= 1'b0;
    cyc(2);
    `CHK(mode, SRBP_CMD)
    `CHK(cfg, CFG_RESET)
    `CHK({rts, txd, peer_valid, radio.role_master, radio.role_slave}, 5'b11000)
    wr_cfg(4'h8, PARITY_EVEN, 1'b1, 1'b0);
    k = falls;
    pulse(4);
    cyc(2000);
    `CHK(falls, k)
    tx(8'ha5, PARITY_EVEN, 1'b0);
    await(n_cmd, 1);
    `CHK({cmd_active, last_cmd}, {1'b1, 8'ha5})
    tx(8'h3c, PARITY_EVEN, 1'b1);
    await(n_par, 1);
    `CHK(n_cmd, 1)
    wr_cfg(4'h8, PARITY_ODD, 1'b1, 1'b1);
    k = falls;
    pulse(4);
    cyc(300);
    `CHK(falls > k, 1'b1)
    tx(8'h96, PARITY_ODD, 1'b0);
    await(n_cmd, 2);
    `CHK(last_cmd, 8'h96)
    wr_mode(MODE_CODE_AUTO);
    `CHK({mode, n_ref}, {SRBP_CMD, 32'd1})
    pulse(3);
    cyc(2);
    `CHK({peer_valid, peer_addr}, {1'b1, link_peer})
    for (k = 1; k < 4; k++) begin
      wr_mode(2'(k));
      `CHK(mode, srbp_mode_e'(4'h1 << k))
      wr_cfg(4'h0, PARITY_NONE, 1'b0, 1'b0);
      pulse(0);
      cyc(2);
      `CHK({mode, cfg.rate_sel, radio.try_connect}, {srbp_mode_e'(4'h1 << k), 4'h8, k == 1})
      wr_mode(MODE_CODE_CMD);
    end
    wr_cfg(4'h8, PARITY_NONE, 1'b1, 1'b0);
    wr_mode(MODE_CODE_OPEN);
    for (k = 0; k < 3; k++) tx(8'h10 + 8'(k), PARITY_NONE, 1'b0);
    `CHK(rts, 1'b0)
    pop(8'h10, 1'b1);
    pulse(2);
    pop(8'h10, 1'b1);
    pulse(1);
    for (i = 0; i < 50 && rts !== 1'b1; i++) @(posedge sys_clk);
    `CHK(rts, 1'b1)
    pop(8'h11, 1'b0);
    pop(8'h12, 1'b1);
    pulse(1);
    wr_mode(MODE_CODE_CMD);
    wr_cfg(4'h8, PARITY_NONE, 1'b0, 1'b0);
    wr_mode(MODE_CODE_OPEN);
    for (k = 0; k < 5; k++) tx(8'h20 + 8'(k), PARITY_NONE, 1'b0);
    `CHK({n_drop > 0, rts}, 2'b11)
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(2);
    `CHK({peer_valid, mode}, {1'b0, SRBP_CMD})
    complete_run();
  end
endmodule
